// ==== core/acr_pkg.sv ====
// Package: register map, field layout and codes of the ADC config bank
package acr_pkg;

    localparam int ACR_NREG = 15;
    localparam logic [7:0] ACR_RESET_VAL = 8'h00;

    // Register offsets
    localparam logic [7:0] ADDR_SOFT_RESET_AND_READBACK = 8'h00;
    localparam logic [7:0] ADDR_OUTPUT_SWING_SELECT = 8'h01;
    localparam logic [7:0] ADDR_PERFORMANCE_MODE_ONE = 8'h03;
    localparam logic [7:0] ADDR_GAIN_AND_PATTERN_SELECT = 8'h25;
    localparam logic [7:0] ADDR_BUFFER_DRIVE_STRENGTH = 8'h26;
    localparam logic [7:0] ADDR_FORMAT_AND_OFFSET_ENABLE = 8'h3d;
    localparam logic [7:0] ADDR_CUSTOM_WORD_HIGH = 8'h3f;
    localparam logic [7:0] ADDR_CUSTOM_WORD_LOW = 8'h40;
    localparam logic [7:0] ADDR_INTERFACE_AND_CLOCK_RISE = 8'h41;
    localparam logic [7:0] ADDR_CLOCK_FALL_LATENCY_STANDBY = 8'h42;
    localparam logic [7:0] ADDR_POWER_DOWN_AND_SWING_ENABLE = 8'h43;
    localparam logic [7:0] ADDR_PERFORMANCE_MODE_TWO = 8'h4a;
    localparam logic [7:0] ADDR_OFFSET_TARGET_LEVEL = 8'hbf;
    localparam logic [7:0] ADDR_OFFSET_LOOP_CONTROL = 8'hcf;
    localparam logic [7:0] ADDR_SLOW_RATE_SELECT = 8'hdf;

    // Storage index of each register, in offset order
    localparam logic [7:0] ACR_ADDR [ACR_NREG] = '{
        ADDR_SOFT_RESET_AND_READBACK,
        ADDR_OUTPUT_SWING_SELECT,
        ADDR_PERFORMANCE_MODE_ONE,
        ADDR_GAIN_AND_PATTERN_SELECT,
        ADDR_BUFFER_DRIVE_STRENGTH,
        ADDR_FORMAT_AND_OFFSET_ENABLE,
        ADDR_CUSTOM_WORD_HIGH,
        ADDR_CUSTOM_WORD_LOW,
        ADDR_INTERFACE_AND_CLOCK_RISE,
        ADDR_CLOCK_FALL_LATENCY_STANDBY,
        ADDR_POWER_DOWN_AND_SWING_ENABLE,
        ADDR_PERFORMANCE_MODE_TWO,
        ADDR_OFFSET_TARGET_LEVEL,
        ADDR_OFFSET_LOOP_CONTROL,
        ADDR_SLOW_RATE_SELECT};
    // Writable bits; reserved bits are not stored and read as zero
    localparam logic [7:0] ACR_WMASK [ACR_NREG] = '{
        8'h01, 8'hfc, 8'h03, 8'hff, 8'h03, 8'he0, 8'hff, 8'hfc,
        8'hff, 8'hcc, 8'h53, 8'h01, 8'hfc, 8'hbc, 8'h30};

    // Field positions
    localparam int BIT_READBACK = 0;
    localparam int BIT_SOFT_RESET = 1;
    localparam int SWING_LSB = 2;
    localparam int GAIN_LSB = 4;
    localparam int BIT_GAIN_DISABLE = 3;
    localparam int PATTERN_LSB = 0;
    localparam int BIT_DATA_DRIVE = 0;
    localparam int BIT_OUTCLK_DRIVE = 1;
    localparam int FORMAT_LSB = 6;
    localparam int BIT_DC_TRIM = 5;
    localparam int BIT_DIGITAL_PATH = 3;
    localparam int SWING_EN_LSB = 0;
    localparam int BIT_PERF_TWO = 0;
    localparam int PERF_ONE_LSB = 0;

    localparam logic [3:0] GAIN_MAX = 4'hc;
    localparam logic [1:0] SWING_EN_ON = 2'h3;
    localparam logic [1:0] FMT_TWOS = 2'h2;
    localparam logic [1:0] FMT_OFFSET = 2'h3;
    localparam logic [13:0] TOGGLE_WORD = 14'h1555;
    localparam logic [1:0] RAMP12_DIV_LAST = 2'h3;
    localparam logic [3:0] SERIAL_LAST_BIT = 4'hf;
    localparam logic [3:0] SERIAL_ADDR_LAST = 4'h7;

    typedef enum logic [2:0] {
        PAT_NORMAL = 3'b000,
        PAT_ZEROS = 3'b001,
        PAT_ONES = 3'b010,
        PAT_TOGGLE = 3'b011,
        PAT_RAMP = 3'b100,
        PAT_CUSTOM = 3'b101,
        PAT_UNUSED6 = 3'b110,
        PAT_UNUSED7 = 3'b111
    } acr_pattern_e;

    // Decoded settings handed to the analog and output stages
    typedef struct packed {
        logic [5:0] swing_code;
        logic [1:0] perf_boost_one;
        logic perf_boost_two;
        logic [3:0] gain_code;
        logic outclk_drive_double;
        logic data_drive_double;
        logic twos_complement;
        logic dc_trim_enable;
        logic digital_path_enable;
    } acr_cfg_s;

endpackage

// ==== core/acr_bank.sv ====
// Serially programmed configuration bank and test-pattern output stage
//
// Contract
// R1 - Soft reset bit clears all, self-clears
// R2 - Readback bit turns shared pin into serial out
// R3 - Swing field selects output amplitude code
// R4 - Swing applies only when swing enable set
// R5 - Controller writes 11 or 00 to boost one
// R6 - Controller enables both performance boosts
// R7 - Gain field, half-dB steps up to 6dB
// R8 - Gain only without disable and low latency
// R9 - Patterns: normal, all zeros, all ones
// R10 - Toggle pattern alternates 0101 and complement
// R11 - 12-bit ramp steps every fourth sample
// R12 - 14-bit ramp steps every sample
// R13 - Custom pattern from two custom registers
// R14 - Controller avoids pattern codes 110, 111
// R15 - Output clock drive strength bit
// R16 - Data output drive strength bit
// R17 - Format field overrides format strap pin
// R18 - All registers reset to zero; one write
// R19 - Sixteen-bit words on falling serial clock
// R20 - Readback mode blocks writes except address zero
// R21 - Swing enable active only at code 11
// R22 - Low latency bypasses gain, patterns, trim
// R23 - Controller writes zeros to reserved bits
// R24 - Patterns replace data with same timing
`timescale 1ns/1ps
`default_nettype none

module acr_bank
    import acr_pkg::*;
#(
    parameter bit RES_14 = 1'b1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic reset_pin,
    input wire logic serial_clk,
    input wire logic serial_select_n,
    input wire logic serial_in_line,
    input wire logic [1:0] format_strap_pin,
    input wire logic sample_valid,
    input wire logic [13:0] sample_data,
    input wire logic overrange,
    output logic overrange_or_readback_pin,
    output logic out_valid,
    output logic [13:0] out_data,
    output acr_cfg_s cfg
);

    // ------------------------------------------------------------
    // Register lookup
    // ------------------------------------------------------------
    function automatic logic [4:0] reg_index(input logic [7:0] addr);
        logic [4:0] idx;
        // Unmapped addresses land past the end of the table
        idx = 5'h1f;
        for (int i = 0; i < ACR_NREG; i++) begin
            if (ACR_ADDR[i] == addr) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclk_s_q;
    logic [1:0] sen_s_q;
    logic [1:0] sdin_s_q;
    logic [1:0] hrst_s_q;
    logic sclk_prev_q;

    // Reset values match the idle pin levels, so no false edge follows
    always_ff @(posedge clock) begin
        if (rst) begin
            sclk_s_q <= 2'h0;
            sen_s_q <= 2'h3;
            sdin_s_q <= 2'h0;
            hrst_s_q <= 2'h0;
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_s_q <= {sclk_s_q[0], serial_clk};
            sen_s_q <= {sen_s_q[0], serial_select_n};
            sdin_s_q <= {sdin_s_q[0], serial_in_line};
            hrst_s_q <= {hrst_s_q[0], reset_pin};
            sclk_prev_q <= sclk_s_q[1];
        end
    end

    logic sclk_fall;
    logic sen_active;
    logic sdin;
    assign sen_active = ~sen_s_q[1];
    assign sdin = sdin_s_q[1];
    // Falling edge of the serial clock while the port is selected
    assign sclk_fall = sen_active & sclk_prev_q & ~sclk_s_q[1]; // [R19]

    // ------------------------------------------------------------
    // Serial shifter
    // ------------------------------------------------------------
    logic [3:0] bit_cnt_q;
    logic [14:0] shift_q;
    logic word_done;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;

    assign word_done = sclk_fall && (bit_cnt_q == SERIAL_LAST_BIT);
    // Address first, then data, taken on the sixteenth edge
    assign wr_addr = shift_q[14:7]; // [R19]
    assign wr_data = {shift_q[6:0], sdin};
    assign rd_addr = {shift_q[6:0], sdin};

    always_ff @(posedge clock) begin
        if (rst || !sen_active) begin
            bit_cnt_q <= 4'h0;
            shift_q <= 15'h0000;
        end else if (sclk_fall) begin
            // Counter wraps so several words fit one select window
            bit_cnt_q <= bit_cnt_q + 4'h1; // [R19]
            shift_q <= {shift_q[13:0], sdin};
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] regs_q [ACR_NREG];
    logic soft_rst_q;
    logic bank_clear;
    logic readback_on;
    logic [4:0] wr_idx;

    assign wr_idx = reg_index(wr_addr);
    assign readback_on = regs_q[0][BIT_READBACK];
    // Pin reset and soft reset share the clear path of rst
    assign bank_clear = rst || hrst_s_q[1] || soft_rst_q;

    // Soft reset lives one cycle only, so the bit never reads back set
    always_ff @(posedge clock) begin
        if (rst || hrst_s_q[1]) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= word_done && wr_addr == ADDR_SOFT_RESET_AND_READBACK
                          && wr_data[BIT_SOFT_RESET]; // [R1]
        end
    end

    generate
        for (genvar g = 0; g < ACR_NREG; g++) begin : g_reg
            always_ff @(posedge clock) begin
                if (bank_clear) begin
                    regs_q[g] <= ACR_RESET_VAL; // [R1] [R18]
                end else if (word_done && wr_idx == 5'(g)
                             && (!readback_on || g == 0)) begin // [R20]
                    // Whole byte at once; reserved bits are dropped
                    regs_q[g] <= wr_data & ACR_WMASK[g]; // [R18]
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Readback shifter
    // ------------------------------------------------------------
    logic [7:0] rd_sh_q;
    logic [4:0] rd_idx;
    logic [7:0] rd_val;

    // The address is complete on the eighth falling edge
    assign rd_idx = reg_index(rd_addr);
    // Address zero cannot be read back and returns zero
    always_comb begin
        rd_val = 8'h00;
        if (rd_idx != 5'h1f && rd_idx != 5'h00) begin
            rd_val = regs_q[rd_idx[3:0]];
        end
    end

    always_ff @(posedge clock) begin
        if (rst || !sen_active || !readback_on) begin
            rd_sh_q <= 8'h00;
        end else if (sclk_fall && bit_cnt_q == SERIAL_ADDR_LAST) begin
            rd_sh_q <= rd_val; // [R2]
        end else if (sclk_fall) begin
            rd_sh_q <= {rd_sh_q[6:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Shared pin
    // ------------------------------------------------------------
    // Over-range comes from the sample side, already on this clock
    always_ff @(posedge clock) begin
        if (rst) begin
            overrange_or_readback_pin <= 1'b0;
        end else begin
            overrange_or_readback_pin <= readback_on ? rd_sh_q[7]
                                                     : overrange; // [R2]
        end
    end

    // ------------------------------------------------------------
    // Format strap synchroniser
    // ------------------------------------------------------------
    // A strap is a board level, yet it is still a pin with no clock
    logic [1:0] strap_s0_q;
    logic [1:0] strap_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            strap_s0_q <= 2'h0;
            strap_q <= 2'h0;
        end else begin
            strap_s0_q <= format_strap_pin;
            strap_q <= strap_s0_q;
        end
    end

    // ------------------------------------------------------------
    // Decoded configuration
    // ------------------------------------------------------------
    logic low_latency;
    logic [1:0] swing_en;
    logic [1:0] fmt_sel;
    logic [3:0] gain_raw;
    acr_pattern_e pattern;

    assign low_latency = ~regs_q[9][BIT_DIGITAL_PATH];
    assign swing_en = regs_q[10][SWING_EN_LSB +: 2];
    assign fmt_sel = regs_q[5][FORMAT_LSB +: 2];
    assign gain_raw = regs_q[3][GAIN_LSB +: 4];
    assign pattern = acr_pattern_e'(regs_q[3][PATTERN_LSB +: 3]);

    always_ff @(posedge clock) begin
        if (rst) begin
            cfg <= '0;
        end else begin
            // Custom swing only under the one legal enable code
            cfg.swing_code <= (swing_en == SWING_EN_ON)
                ? regs_q[1][SWING_LSB +: 6] : 6'h00; // [R3] [R4] [R21]
            cfg.perf_boost_one <= regs_q[2][PERF_ONE_LSB +: 2];
            cfg.perf_boost_two <= regs_q[11][BIT_PERF_TWO];
            // Codes above 6dB are clamped rather than left undefined
            cfg.gain_code <= (regs_q[3][BIT_GAIN_DISABLE] || low_latency)
                ? 4'h0
                : (gain_raw > GAIN_MAX ? GAIN_MAX : gain_raw); // [R7] [R8] [R22]
            cfg.outclk_drive_double <= regs_q[4][BIT_OUTCLK_DRIVE]; // [R15]
            cfg.data_drive_double <= regs_q[4][BIT_DATA_DRIVE]; // [R16]
            cfg.twos_complement <= (fmt_sel == FMT_TWOS) ? 1'b1
                : (fmt_sel == FMT_OFFSET) ? 1'b0
                : ~strap_q[1]; // [R17]
            cfg.dc_trim_enable <= regs_q[5][BIT_DC_TRIM] & ~low_latency; // [R22]
            cfg.digital_path_enable <= ~low_latency;
        end
    end

    // ------------------------------------------------------------
    // Test-pattern generators
    // ------------------------------------------------------------
    logic toggle_q;
    logic [13:0] ramp_q;
    logic [1:0] ramp_div_q;

    // Each generator restarts from its first word when picked again
    always_ff @(posedge clock) begin
        if (bank_clear || pattern != PAT_TOGGLE) begin
            toggle_q <= 1'b0;
        end else if (sample_valid) begin
            toggle_q <= ~toggle_q; // [R10]
        end
    end

    always_ff @(posedge clock) begin
        if (bank_clear || pattern != PAT_RAMP) begin
            ramp_q <= 14'h0000;
            ramp_div_q <= 2'h0;
        end else if (sample_valid) begin
            if (RES_14) begin
                ramp_q <= ramp_q + 14'h0001; // [R12]
            end else begin
                ramp_div_q <= ramp_div_q + 2'h1;
                if (ramp_div_q == RAMP12_DIV_LAST) begin
                    // Wraps after 4095 through the 12-bit width
                    ramp_q <= {2'b00, ramp_q[11:0] + 12'h001}; // [R11]
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Output word selection
    // ------------------------------------------------------------
    logic [13:0] width_mask;
    logic [13:0] custom_word;
    logic [13:0] conv_word;
    logic [13:0] pat_word;
    logic [13:0] msb_bit;

    assign width_mask = RES_14 ? 14'h3fff : 14'h0fff;
    assign msb_bit = RES_14 ? 14'h2000 : 14'h0800;
    // The 12-bit variant takes the upper twelve custom bits
    assign custom_word = RES_14
        ? {regs_q[6], regs_q[7][7:2]}
        : {2'b00, regs_q[6], regs_q[7][7:4]}; // [R13]
    // Incoming samples are offset binary; flip the sign bit for twos
    assign conv_word = (sample_data & width_mask)
                       ^ (cfg.twos_complement ? msb_bit : 14'h0000);

    always_comb begin
        // Unused codes pass live data rather than freeze the bus
        unique case (pattern)
            PAT_NORMAL: pat_word = conv_word; // [R9]
            PAT_ZEROS: pat_word = 14'h0000; // [R9]
            PAT_ONES: pat_word = width_mask; // [R9]
            PAT_TOGGLE: pat_word = (toggle_q ? ~TOGGLE_WORD : TOGGLE_WORD)
                                   & width_mask; // [R10]
            PAT_RAMP: pat_word = ramp_q & width_mask;
            PAT_CUSTOM: pat_word = custom_word; // [R13]
            PAT_UNUSED6: pat_word = conv_word;
            PAT_UNUSED7: pat_word = conv_word;
        endcase
    end

    // Same register stage for every source keeps timing identical
    always_ff @(posedge clock) begin
        if (rst) begin
            out_data <= 14'h0000;
            out_valid <= 1'b0;
        end else begin
            out_valid <= sample_valid;
            if (sample_valid) begin
                out_data <= low_latency ? conv_word : pat_word; // [R22] [R24]
            end
        end
    end

endmodule

`default_nettype wire

// ==== tb/acr_bank_assertions.sv ====
// Checker: port-level properties of the config bank
`timescale 1ns/1ps
`default_nettype none
module acr_bank_assertions
    import acr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic reset_pin,
    input wire logic serial_select_n,
    input wire logic [1:0] format_strap_pin,
    input wire logic sample_valid,
    input wire logic [13:0] sample_data,
    input wire logic out_valid,
    input wire logic [13:0] out_data,
    input wire acr_cfg_s cfg
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Quiet-port counter
    // ------------------------------------------------------------
    // Cleared by all that may legally move cfg, so a cfg change with the port idle shows
    logic [3:0] quiet_q;
    always_ff @(posedge clock) begin
        if (rst || !serial_select_n || reset_pin
            || $changed(format_strap_pin)) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hf) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    valid_follow_a: assert property (
        sample_valid |=> out_valid)
        else $error("out_valid missing after a sample");
    valid_cause_a: assert property (
        out_valid |-> $past(sample_valid))
        else $error("out_valid without a sample");
    data_hold_a: assert property (
        !out_valid |-> $stable(out_data))
        else $error("out_data moved without out_valid");
    bypass_data_a: assert property (
        sample_valid && !cfg.digital_path_enable |=> out_data ==
        ($past(sample_data) ^ {$past(cfg.twos_complement), 13'h0}))
        else $error("low-latency output differs from formatted sample");
    gain_limit_a: assert property (
        cfg.gain_code <= GAIN_MAX)
        else $error("gain code above the top step");
    reset_clear_a: assert property (disable iff (1'b0)
        rst |=> !out_valid && out_data == 14'h0 && cfg == acr_cfg_s'(0))
        else $error("outputs not cleared by reset");
    cfg_quiet_a: assert property (
        quiet_q == 4'hf |-> $stable(cfg))
        else $error("cfg moved with the serial port idle");
    pin_reset_a: assert property (
        reset_pin [*6] |-> cfg.gain_code == 4'h0 && cfg.swing_code == 6'h0
        && !cfg.data_drive_double)
        else $error("reset pin did not clear the settings");
    path_on_c: cover property (out_valid && cfg.digital_path_enable);
    pin_reset_c: cover property (reset_pin [*6]);
    offset_fmt_c: cover property (out_valid && !cfg.twos_complement);
endmodule

bind acr_bank acr_bank_assertions u_acr_chk (
    .clock(clock), .rst(rst), .reset_pin(reset_pin),
    .serial_select_n(serial_select_n), .format_strap_pin(format_strap_pin),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .out_valid(out_valid), .out_data(out_data), .cfg(cfg));
`default_nettype wire

// ==== tb/acr_ctrl_model.sv ====
// Controller model: drives the three-wire serial port, samples readback
`timescale 1ns/1ps
`default_nettype none
module acr_ctrl_model (
    input wire logic clock,
    input wire logic readback_pin,
    output logic serial_clk,
    output logic serial_select_n,
    output logic serial_in_line
);
    // Half period in clocks; the readback round trip needs at least 2
    int half = 4;
    initial begin
        serial_clk = 1'b0;
        serial_select_n = 1'b1;
        serial_in_line = 1'b0;
    end
    // Clock idles low outside frames; data line shows junk when idle
    task automatic xfer(input logic [31:0] w, input int n,
                        output logic [7:0] rd);
        rd = 8'h00;
        @(negedge clock);
        serial_select_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            repeat (half) @(negedge clock);
            serial_clk <= 1'b1;
            // Data moves on the rising edge so it holds across the fall
            serial_in_line <= w[31-i];
            repeat (half) @(negedge clock);
            if (i >= 8 && i < 16) begin
                rd = {rd[6:0], readback_pin};
            end
            serial_clk <= 1'b0;
        end
        repeat (half) @(negedge clock);
        serial_select_n <= 1'b1;
        serial_in_line <= ~serial_in_line;
        repeat (2 * half) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// ==== tb/acr_bank_test.sv ====
// Testbench: serial programming, readback and sample path of acr_bank
`timescale 1ns/1ps
`default_nettype none
module acr_bank_test
    import acr_pkg::*;
;
    localparam acr_cfg_s CFG_RST = '{twos_complement: 1'b1, default: '0};
    localparam acr_cfg_s CFG_ALL = '{6'h3f, 2'h3, 1'b1, 4'hc, 1'b1, 1'b1,
        1'b0, 1'b1, 1'b1};
    logic clock, rst, reset_pin, sample_valid, overrange, pin, out_valid;
    logic serial_clk, serial_select_n, serial_in_line;
    logic [1:0] format_strap_pin;
    logic [13:0] sample_data, out_data;
    logic [7:0] r;
    acr_cfg_s cfg;
    int miscompares = 0;
    int tests_run = 0;
    always #10 clock = ~clock;
    acr_bank #(.RES_14(1'b1)) dut (
        .clock(clock), .rst(rst), .reset_pin(reset_pin),
        .serial_clk(serial_clk), .serial_select_n(serial_select_n),
        .serial_in_line(serial_in_line), .format_strap_pin(format_strap_pin),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .overrange(overrange), .overrange_or_readback_pin(pin),
        .out_valid(out_valid), .out_data(out_data), .cfg(cfg));
    acr_ctrl_model ctl (.clock(clock), .readback_pin(pin),
        .serial_clk(serial_clk), .serial_select_n(serial_select_n),
        .serial_in_line(serial_in_line));
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [19:0] seen,
                       input logic [19:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ctl.xfer({a, d, 16'h0}, 16, r);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        // Data 01 keeps readback on when the address is zero
        ctl.xfer({a, 8'h01, 16'h0}, 16, r);
        chk("readback", {12'h0, r}, {12'h0, e});
    endtask
    task automatic smpchk(input logic [13:0] d, input logic [13:0] e);
        @(negedge clock);
        sample_data = d;
        sample_valid = 1'b1;
        @(negedge clock);
        sample_valid = 1'b0;
        chk("out_valid", {19'h0, out_valid}, 20'h1);
        chk("out_data", {6'h0, out_data}, {6'h0, e});
    endtask
    // Reg 25 is given a legal pattern code instead of its full mask
    function automatic logic [7:0] wval(input int i);
        return (i == 3) ? 8'hc4 : ACR_WMASK[i];
    endfunction
    function automatic logic [13:0] pexp(input int c, input int k);
        case (c)
            0: return (14'h0123 + k[13:0]) ^ 14'h2000;
            1: return 14'h0000;
            2: return 14'h3fff;
            3: return k[0] ? 14'h2aaa : 14'h1555;
            4: return k[13:0];
            default: return 14'h2af3;
        endcase
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #1000000;
        miscompares++;
        summarize();
    end
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        reset_pin = 1'b0;
        sample_valid = 1'b0;
        sample_data = 14'h0000;
        overrange = 1'b0;
        format_strap_pin = 2'h0;
        repeat (5) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        chk("cfg", {2'h0, cfg}, {2'h0, CFG_RST});
        wr(8'h00, 8'h01);
        for (int i = 0; i < ACR_NREG; i++) rdchk(ACR_ADDR[i], 8'h00);
        wr(8'h00, 8'h00);
        $display("test reset_values done");
        for (int i = 1; i < ACR_NREG; i++) wr(ACR_ADDR[i], wval(i));
        chk("cfg", {2'h0, cfg}, {2'h0, CFG_ALL});
        wr(8'h00, 8'h01);
        for (int i = 0; i < ACR_NREG; i++) begin
            rdchk(ACR_ADDR[i], (i == 0) ? 8'h00 : wval(i));
        end
        wr(8'h26, 8'h00);
        rdchk(8'h26, 8'h03);
        wr(8'h00, 8'h00);
        wr(8'h00, 8'h02);
        chk("cfg", {2'h0, cfg}, {2'h0, CFG_RST});
        wr(8'h00, 8'h01);
        rdchk(8'h25, 8'h00);
        wr(8'h00, 8'h00);
        $display("test program_and_soft_reset done");
        wr(8'h42, 8'h08);
        wr(8'h3f, 8'hab);
        wr(8'h40, 8'hcc);
        for (int c = 0; c < 6; c++) begin
            wr(8'h25, 8'(c));
            for (int k = 0; k < 3; k++) begin
                smpchk(14'h0123 + 14'(k), pexp(c, k));
            end
        end
        wr(8'h25, 8'hf0);
        chk("gain", {16'h0, cfg.gain_code}, 20'h0000c);
        wr(8'h25, 8'hc8);
        chk("gain", {16'h0, cfg.gain_code}, 20'h00000);
        smpchk(14'h0123, 14'h2123);
        wr(8'h42, 8'h00);
        wr(8'h25, 8'hc2);
        chk("gain", {16'h0, cfg.gain_code}, 20'h00000);
        smpchk(14'h0123, 14'h2123);
        wr(8'h3d, 8'h80);
        smpchk(14'h0123, 14'h2123);
        wr(8'h3d, 8'hc0);
        smpchk(14'h0123, 14'h0123);
        wr(8'h3d, 8'h00);
        format_strap_pin = 2'h2;
        // The strap passes a synchroniser before it reaches cfg
        repeat (3) @(negedge clock);
        smpchk(14'h0123, 14'h0123);
        $display("test sample_path done");
        overrange = 1'b1;
        // Long idle lets the checker see cfg with the port quiet
        repeat (16) @(negedge clock);
        chk("pin", {19'h0, pin}, 20'h1);
        overrange = 1'b0;
        repeat (3) @(negedge clock);
        chk("pin", {19'h0, pin}, 20'h0);
        ctl.xfer({8'h26, 8'h01, 8'hf0, 8'h00}, 20, r);
        ctl.xfer({8'h26, 24'h0}, 8, r);
        ctl.half = 9;
        wr(8'h00, 8'h01);
        rdchk(8'h26, 8'h01);
        ctl.half = 4;
        wr(8'h00, 8'h00);
        reset_pin = 1'b1;
        repeat (8) @(negedge clock);
        reset_pin = 1'b0;
        repeat (4) @(negedge clock);
        wr(8'h00, 8'h01);
        rdchk(8'h3f, 8'h00);
        $display("test pins_and_framing done");
        summarize();
    end
endmodule
`default_nettype wire
